// File: lcc_regs.sv
// Channel C pattern register bank with prescaler and sequence timer
`timescale 1ns/1ns
module lcc_regs #(
   parameter int OSC_DIV    = lcc_pkg::LCC_OSC_DIV,
   parameter int STEP_TICKS = lcc_pkg::LCC_STEP_TCK,
   parameter int RAMP_TICKS = lcc_pkg::LCC_RAMP_TCK
) (
   // Clock and reset
   input  wire  logic                          core_clk,
   input  wire  logic                          rst_b,
   // Register port from the serial control interface
   input  wire  logic [7:0]                    reg_addr,
   input  wire  logic [7:0]                    reg_wdata,
   input  wire  logic                          reg_wr,
   input  wire  logic                          reg_rd,
   output logic       [7:0]                    reg_rdata,
   output logic                                reg_rvalid,
   // Sequence control
   input  wire  logic                          seq_en,
   // Channel settings to the current sink
   output logic                                chan_c_ramp_on,
   output logic       [lcc_pkg::LCC_CUR_W-1:0] chan_c_sink_level,
   output logic     [lcc_pkg::LCC_RAMPT_W-1:0] shared_rise_time,
   output logic     [lcc_pkg::LCC_RAMPT_W-1:0] shared_fall_time,
   output logic                                ramp_step,
   // Sequence state
   output lcc_pkg::lcc_phase_t                 seq_phase,
   output logic                                seq_phase_end
);
   import lcc_pkg::*;

   lcc_seq_if sq ();                                  // Carrier to timer

   logic                   ramp_r, ramp_nxt;          // Ramp enable
   logic [LCC_CUR_W-1:0]   cur_r, cur_nxt;            // Sink-current code
   logic [LCC_LEN_W-1:0]   len_r [5];                 // Phase lengths
   logic [LCC_LEN_W-1:0]   len_nxt [5];
   logic [LCC_RAMPT_W-1:0] rise_r, rise_nxt;          // Shared rise time
   logic [LCC_RAMPT_W-1:0] fall_r, fall_nxt;          // Shared fall time
   logic [7:0]             rdata_r, rdata_nxt;        // Read data
   logic                   rvalid_r, rvalid_nxt;      // Read data valid
   logic [11:0]            osc_cnt_r, osc_cnt_nxt;    // Oscillator prescaler
   logic                   osc_tick_r, osc_tick_nxt;  // 32 kHz enable
   logic [8:0]             rmp_cnt_r, rmp_cnt_nxt;    // 8 ms divider
   logic                   rstep_r, rstep_nxt;        // 8 ms step pulse
   logic                   seq_en_m, seq_en_s;        // Pin synchroniser

   // Index of a phase-length register, 5 if none
   function automatic logic [2:0] len_idx(input logic [7:0] a);
      case (a)
         LCC_OFS_PH1:   len_idx = 3'd0;
         LCC_OFS_PH2:   len_idx = 3'd1;
         LCC_OFS_PH3:   len_idx = 3'd2;
         LCC_OFS_PH4:   len_idx = 3'd3;
         LCC_OFS_PAUSE: len_idx = 3'd4;
         default:       len_idx = 3'd5;
      endcase
   endfunction

   // Register writes; only defined fields are stored
   always_comb begin
      ramp_nxt = ramp_r;
      cur_nxt  = cur_r;
      rise_nxt = rise_r;
      fall_nxt = fall_r;
      len_nxt  = len_r;
      if (reg_wr) begin
         case (reg_addr)
            LCC_OFS_RAMP_CUR: begin
               ramp_nxt = reg_wdata[LCC_RAMP_BIT];
               cur_nxt  = reg_wdata[LCC_CUR_W-1:0];
            end
            LCC_OFS_RISE: rise_nxt = reg_wdata[LCC_RAMPT_W-1:0];
            LCC_OFS_FALL: fall_nxt = reg_wdata[LCC_RAMPT_W-1:0];
            default: begin
               // Phase lengths; bit 7 dropped
               if (len_idx(reg_addr) != 3'd5) begin
                  len_nxt[len_idx(reg_addr)] = reg_wdata[LCC_LEN_W-1:0];
               end
            end
         endcase
      end
   end

   // Read mux; reserved and unmapped bits return zero
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = reg_rd;
      if (reg_rd) begin
         rdata_nxt = 8'h00;
         case (reg_addr)
            LCC_OFS_RAMP_CUR: begin
               rdata_nxt[LCC_RAMP_BIT]    = ramp_r;
               rdata_nxt[LCC_CUR_W-1:0]   = cur_r;
            end
            LCC_OFS_RISE: rdata_nxt[LCC_RAMPT_W-1:0] = rise_r;
            LCC_OFS_FALL: rdata_nxt[LCC_RAMPT_W-1:0] = fall_r;
            default: begin
               if (len_idx(reg_addr) != 3'd5) begin
                  rdata_nxt[LCC_LEN_W-1:0] = len_r[len_idx(reg_addr)];
               end
            end
         endcase
      end
   end

   // Free-running prescaler and 8 ms ramp divider
   always_comb begin
      osc_tick_nxt = 1'b0;
      rstep_nxt    = 1'b0;
      rmp_cnt_nxt  = rmp_cnt_r;
      if (osc_cnt_r == 12'(OSC_DIV - 1)) begin
         osc_cnt_nxt  = '0;
         osc_tick_nxt = 1'b1;
      end else begin
         osc_cnt_nxt = osc_cnt_r + 12'd1;
      end
      if (osc_tick_r) begin
         if (rmp_cnt_r == 9'(RAMP_TICKS - 1)) begin
            rmp_cnt_nxt = '0;
            rstep_nxt   = ramp_r;
         end else begin
            rmp_cnt_nxt = rmp_cnt_r + 9'd1;
         end
      end
   end

   // State registers, all cleared by reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ramp_r     <= 1'b0;
         cur_r      <= LCC_RST_VAL[LCC_CUR_W-1:0];
         len_r      <= '{default: LCC_RST_VAL[LCC_LEN_W-1:0]};
         rise_r     <= LCC_RST_VAL[LCC_RAMPT_W-1:0];
         fall_r     <= LCC_RST_VAL[LCC_RAMPT_W-1:0];
         rdata_r    <= LCC_RST_VAL;
         rvalid_r   <= 1'b0;
         osc_cnt_r  <= '0;
         osc_tick_r <= 1'b0;
         rmp_cnt_r  <= '0;
         rstep_r    <= 1'b0;
         seq_en_m   <= 1'b0;
         seq_en_s   <= 1'b0;
      end else begin
         ramp_r     <= ramp_nxt;
         cur_r      <= cur_nxt;
         len_r      <= len_nxt;
         rise_r     <= rise_nxt;
         fall_r     <= fall_nxt;
         rdata_r    <= rdata_nxt;
         rvalid_r   <= rvalid_nxt;
         osc_cnt_r  <= osc_cnt_nxt;
         osc_tick_r <= osc_tick_nxt;
         rmp_cnt_r  <= rmp_cnt_nxt;
         rstep_r    <= rstep_nxt;
         seq_en_m   <= seq_en;
         seq_en_s   <= seq_en_m;
      end
   end

   // Feed the timer
   assign sq.len      = len_r;
   assign sq.run      = seq_en_s;
   assign sq.osc_tick = osc_tick_r;

   // Sequence timer
   lcc_seq_timer #(
      .STEP_TICKS (STEP_TICKS)
   ) u_tmr (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .sq       (sq.tmr)
   );

   // Outputs, all from flops
   assign reg_rdata         = rdata_r;
   assign reg_rvalid        = rvalid_r;
   assign chan_c_ramp_on    = ramp_r;
   assign chan_c_sink_level = cur_r;
   assign shared_rise_time  = rise_r;
   assign shared_fall_time  = fall_r;
   assign ramp_step         = rstep_r;
   assign seq_phase         = sq.phase;
   assign seq_phase_end     = sq.phase_end;
endmodule

// File: lcc_pkg.sv
// Package with constants for the channel C pattern register bank
// Behaviour
// - Reserved bits are read-only and read zero
// - Bit 5 selects abrupt or ramped switching
// - Bits 3:0 hold writable sink-current code
// - Phase 1 length is field times 64 ms
// - Phase 2 length is field times 64 ms
// - Phase 3 length is field times 64 ms
// - Phase 4 length is field times 64 ms
// - Pause length is field times 64 ms
// - Reset clears every pattern register to zero
// - Shared rise time is setting times 8 ms
// - Shared fall time is setting times 8 ms
package lcc_pkg;
   // Register offsets
   localparam logic [7:0] LCC_OFS_RAMP_CUR = 8'h57;
   localparam logic [7:0] LCC_OFS_PH1      = 8'h58;
   localparam logic [7:0] LCC_OFS_PH2      = 8'h59;
   localparam logic [7:0] LCC_OFS_PH3      = 8'h5a;
   localparam logic [7:0] LCC_OFS_PH4      = 8'h5b;
   localparam logic [7:0] LCC_OFS_PAUSE    = 8'h5c;
   localparam logic [7:0] LCC_OFS_RISE     = 8'h5f;
   localparam logic [7:0] LCC_OFS_FALL     = 8'h60;
   // Field positions and widths
   localparam int LCC_RAMP_BIT  = 5;
   localparam int LCC_CUR_W     = 4;
   localparam int LCC_LEN_W     = 7;
   localparam int LCC_RAMPT_W   = 5;
   // Value after reset
   localparam logic [7:0] LCC_RST_VAL = 8'h00;
   // Timing figures in their own units
   localparam int LCC_CLK_HZ    = 50_000_000;
   localparam int LCC_OSC_HZ    = 32_000;
   localparam int LCC_STEP_MS   = 64;
   localparam int LCC_RAMP_MS   = 8;
   // Derived counts: clock cycles per oscillator tick, ticks per step
   localparam int LCC_OSC_DIV   = LCC_CLK_HZ / LCC_OSC_HZ;
   localparam int LCC_STEP_TCK  = LCC_OSC_HZ * LCC_STEP_MS / 1000;
   localparam int LCC_RAMP_TCK  = LCC_OSC_HZ * LCC_RAMP_MS / 1000;
   // Sequence phases, Gray coded on each step except pause to phase 1
   typedef enum logic [2:0] {
      LCC_IDLE  = 3'b000,
      LCC_PH1   = 3'b001,
      LCC_PH2   = 3'b011,
      LCC_PH3   = 3'b010,
      LCC_PH4   = 3'b110,
      LCC_PAUSE = 3'b111
   } lcc_phase_t;
endpackage

// File: lcc_seq_if.sv
// Interface joining register bank and sequence timer
`timescale 1ns/1ns
interface lcc_seq_if;
   import lcc_pkg::*;
   logic [LCC_LEN_W-1:0] len [5];   // Phase lengths, order 1,2,3,4,pause
   logic                 run;       // Sequence enabled
   logic                 osc_tick;  // 32 kHz tick enable
   lcc_phase_t           phase;     // Current phase
   logic                 phase_end; // Pulse at end of a phase
   modport ctl (output len, output run, output osc_tick, input phase, input phase_end);
   modport tmr (input len, input run, input osc_tick, output phase, output phase_end);
endinterface

// File: lcc_seq_timer.sv
// Sequence timer stepping through the five phases of channel C
`timescale 1ns/1ns
module lcc_seq_timer #(
   parameter int STEP_TICKS = lcc_pkg::LCC_STEP_TCK
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // Timer side of the carrier
   lcc_seq_if.tmr    sq
);
   import lcc_pkg::*;

   lcc_phase_t           ph_r, ph_nxt;         // Phase state
   logic [11:0]          tick_r, tick_nxt;     // Ticks within one step
   logic [LCC_LEN_W-1:0] steps_r, steps_nxt;   // Steps spent in phase
   logic                 end_r, end_nxt;       // Phase end pulse

   // Next phase along the loop
   function automatic lcc_phase_t next_ph(input lcc_phase_t p);
      case (p)
         LCC_PH1:   next_ph = LCC_PH2;
         LCC_PH2:   next_ph = LCC_PH3;
         LCC_PH3:   next_ph = LCC_PH4;
         LCC_PH4:   next_ph = LCC_PAUSE;
         default:   next_ph = LCC_PH1;
      endcase
   endfunction

   // Length field of a phase
   function automatic logic [LCC_LEN_W-1:0] len_of(input lcc_phase_t p);
      case (p)
         LCC_PH1:   len_of = sq.len[0];
         LCC_PH2:   len_of = sq.len[1];
         LCC_PH3:   len_of = sq.len[2];
         LCC_PH4:   len_of = sq.len[3];
         LCC_PAUSE: len_of = sq.len[4];
         default:   len_of = '0;
      endcase
   endfunction

   // Phase and step counting
   always_comb begin
      ph_nxt    = ph_r;
      tick_nxt  = tick_r;
      steps_nxt = steps_r;
      end_nxt   = 1'b0;
      if (!sq.run) begin
         // Stopped: hold idle
         ph_nxt    = LCC_IDLE;
         tick_nxt  = '0;
         steps_nxt = '0;
      end else if (ph_r == LCC_IDLE) begin
         // Start with phase 1
         ph_nxt = LCC_PH1;
      end else if (steps_r >= len_of(ph_r)) begin
         // Length reached; zero length passes at once
         ph_nxt    = next_ph(ph_r);
         tick_nxt  = '0;
         steps_nxt = '0;
         end_nxt   = 1'b1;
      end else if (sq.osc_tick) begin
         // One 64 ms step is STEP_TICKS oscillator ticks
         if (tick_r == 12'(STEP_TICKS - 1)) begin
            tick_nxt  = '0;
            steps_nxt = steps_r + 7'd1;
         end else begin
            tick_nxt = tick_r + 12'd1;
         end
      end
   end

   // Registers, cleared by reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ph_r    <= LCC_IDLE;
         tick_r  <= '0;
         steps_r <= '0;
         end_r   <= 1'b0;
      end else begin
         ph_r    <= ph_nxt;
         tick_r  <= tick_nxt;
         steps_r <= steps_nxt;
         end_r   <= end_nxt;
      end
   end

   assign sq.phase     = ph_r;
   assign sq.phase_end = end_r;
endmodule

// File: lcc_regs_properties.sv
// Concurrent checks on the ports of the channel C pattern register bank
`timescale 1ns/1ns
module lcc_regs_properties
   import lcc_pkg::*;
(
   // Clock and reset
   input wire logic                         core_clk,
   input wire logic                         rst_b,
   // Register port
   input wire logic [7:0]                   reg_addr,
   input wire logic [7:0]                   reg_wdata,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_rdata,
   input wire logic                         reg_rvalid,
   // Channel settings and sequence state
   input wire logic                         chan_c_ramp_on,
   input wire logic [LCC_CUR_W-1:0]         chan_c_sink_level,
   input wire logic [LCC_RAMPT_W-1:0]       shared_rise_time,
   input wire logic [LCC_RAMPT_W-1:0]       shared_fall_time,
   input wire logic                         ramp_step,
   input wire lcc_phase_t                   seq_phase,
   input wire logic                         seq_phase_end
);
   // Successor of each phase code, indexed by the current code
   localparam logic [2:0] NXT [8] = '{3'h1, 3'h3, 3'h6, 3'h2, 3'h0, 3'h0, 3'h7, 3'h1};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Read handshake
   chk_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   chk_rvalid_only_rd: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read valid");
   // Writes reach the channel outputs one cycle later
   chk_ramp_write: assert property (reg_wr && reg_addr == LCC_OFS_RAMP_CUR |=> chan_c_ramp_on == $past(reg_wdata[5]))
      else $error("ramp bit not written");
   chk_level_write: assert property (reg_wr && reg_addr == LCC_OFS_RAMP_CUR |=> chan_c_sink_level == $past(reg_wdata[3:0]))
      else $error("sink level not written");
   chk_rise_write: assert property (reg_wr && reg_addr == LCC_OFS_RISE |=> shared_rise_time == $past(reg_wdata[4:0]))
      else $error("rise time not written");
   chk_fall_write: assert property (reg_wr && reg_addr == LCC_OFS_FALL |=> shared_fall_time == $past(reg_wdata[4:0]))
      else $error("fall time not written");
   // Reserved bit 7 of the phase lengths and unmapped addresses read zero
   chk_rsvd_read_zero: assert property (reg_rd && reg_addr inside {[8'h58:8'h5c]} |=> reg_rdata[7] == 1'b0)
      else $error("reserved bit reads one");
   chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[8'h57:8'h5c], 8'h5f, 8'h60}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // Phases follow the fixed order
   chk_phase_order: assert property ($changed(seq_phase) && seq_phase != LCC_IDLE |-> seq_phase == NXT[$past(seq_phase)])
      else $error("phase order broken");
   // Phase end pulse marks exactly the steps between running phases
   chk_end_after_step: assert property (seq_phase_end |-> seq_phase != $past(seq_phase)
      && $past(seq_phase) != LCC_IDLE) else $error("phase end without step");
   chk_step_gives_end: assert property ($changed(seq_phase) && seq_phase != LCC_IDLE
      && $past(seq_phase) != LCC_IDLE |-> seq_phase_end) else $error("phase step without end");
   // No ramp steps once ramping has been off for three cycles
   chk_ramp_quiet: assert property ((!chan_c_ramp_on)[*3] |-> !ramp_step)
      else $error("ramp step while ramp off");
   cov_ramp_step: cover property (chan_c_ramp_on && ramp_step);
   cov_pause: cover property (seq_phase == LCC_PAUSE ##1 seq_phase == LCC_PH1);
   cov_unmapped: cover property (reg_rd && reg_addr == 8'h5d);
endmodule
bind lcc_regs lcc_regs_properties i_lcc_regs_properties (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .chan_c_ramp_on(chan_c_ramp_on), .chan_c_sink_level(chan_c_sink_level), .shared_rise_time(shared_rise_time),
   .shared_fall_time(shared_fall_time), .ramp_step(ramp_step), .seq_phase(seq_phase),
   .seq_phase_end(seq_phase_end));

// File: lcc_regs_bench.sv
// Self-checking bench for the channel C pattern register bank
`timescale 1ns/1ns
module lcc_regs_bench;
   import lcc_pkg::*;
   localparam int OD = 2;                   // Shortened oscillator divider
   localparam int ST = 2;                   // Shortened ticks per step
   localparam int RT = 2;                   // Shortened ticks per ramp step
   logic             core_clk  = 1'b0;      // Core clock
   logic             rst_b     = 1'b0;      // Reset, active low
   logic [7:0]       reg_addr  = 8'h00;     // Register address
   logic [7:0]       reg_wdata = 8'h00;     // Write data
   logic             reg_wr    = 1'b0;      // Write strobe
   logic             reg_rd    = 1'b0;      // Read strobe
   logic             seq_en    = 1'b0;      // Sequence run
   logic [7:0]       reg_rdata;             // Read data
   logic             reg_rvalid;            // Read valid
   logic             chan_c_ramp_on;        // Ramp mode
   logic [3:0]       chan_c_sink_level;     // Current code
   logic [4:0]       shared_rise_time;      // Rise setting
   logic [4:0]       shared_fall_time;      // Fall setting
   logic             ramp_step;             // Ramp step pulse
   lcc_phase_t       seq_phase;             // Current phase
   logic             seq_phase_end;         // Phase end pulse
   int               errors      = 0;       // Mismatch count
   int               check_count = 0;       // Comparison count
   // Address table and readable masks
   logic [7:0] addr_t [8] = '{8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5f, 8'h60};
   logic [7:0] mask_t [8] = '{8'h2f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h1f, 8'h1f};
   lcc_phase_t ord_t [5]  = '{LCC_PH1, LCC_PH2, LCC_PH3, LCC_PH4, LCC_PAUSE};
   lcc_regs #(.OSC_DIV(OD), .STEP_TICKS(ST), .RAMP_TICKS(RT)) i_lcc_regs (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .seq_en(seq_en), .chan_c_ramp_on(chan_c_ramp_on),
      .chan_c_sink_level(chan_c_sink_level), .shared_rise_time(shared_rise_time),
      .shared_fall_time(shared_fall_time), .ramp_step(ramp_step), .seq_phase(seq_phase),
      .seq_phase_end(seq_phase_end));
   // Clock generator
   always #10 core_clk = ~core_clk;
   // Verdict and end of run
   task summarize;
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Byte compare
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Cycle count compare against a window
   task cmp_rng(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // One clock, inputs change just after the edge
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   // Register write and checked read
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a; reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      cmp({7'h0, reg_rvalid}, 8'h01);
      cmp(reg_rdata, exp);
   endtask
   // Bounded wait for a phase
   task wait_ph(input lcc_phase_t p);
      int n;
      n = 0;
      while (seq_phase !== p && n < 200) begin
         tick; n++;
      end
      if (seq_phase !== p) begin
         cmp_rng(n, 0, 199);
         summarize;
      end
   endtask
   // Bounded wait for a ramp step, counting on from n
   task wait_rstep(inout int n);
      while (ramp_step !== 1'b1 && n < 50) begin tick; n++; end
      if (ramp_step !== 1'b1) begin
         cmp_rng(n, 0, 49);
         summarize;
      end
   endtask
   // Reset values of every register and of the channel and phase outputs
   task t_reset;
      for (int i = 0; i < 8; i++) rd_chk(addr_t[i], 8'h00);
      cmp({2'h0, chan_c_ramp_on, 1'b0, chan_c_sink_level}, 8'h00);
      cmp({3'h0, shared_rise_time}, 8'h00);
      cmp({3'h0, shared_fall_time}, 8'h00);
      cmp({5'h0, seq_phase}, 8'h00);
   endtask
   // Reset in mid-run clears every register again
   task t_rst_mid;
      rst_b = 1'b0;
      repeat (2) tick;
      rst_b = 1'b1;
      t_reset;
   endtask
   // Writable fields, reserved bits, unmapped address
   task t_fields;
      for (int i = 0; i < 8; i++) begin
         wr(addr_t[i], 8'hff);
         rd_chk(addr_t[i], mask_t[i]);
      end
      cmp({3'h0, shared_rise_time}, 8'h1f);
      cmp({3'h0, shared_fall_time}, 8'h1f);
      wr(8'h57, 8'hd0);
      rd_chk(8'h57, 8'h00);
      wr(8'h57, 8'h25);
      cmp({2'h0, chan_c_ramp_on, 1'b0, chan_c_sink_level}, 8'h25);
      wr(8'h5d, 8'hff);
      rd_chk(8'h5d, 8'h00);
   endtask
   // Ramp step spacing while on, silence while off
   task t_ramp;
      int n;
      n = 0;
      wait_rstep(n);
      tick; n = 1;
      wait_rstep(n);
      cmp_rng(n, OD * RT, OD * RT);
      wr(8'h57, 8'h05);
      repeat (3) tick;
      n = 0;
      repeat (20) begin if (ramp_step !== 1'b0) n++; tick; end
      cmp_rng(n, 0, 0);
   endtask
   // Zero-length phases pass in one cycle each
   task t_seq_zero;
      for (int i = 1; i < 6; i++) wr(addr_t[i], 8'h00);
      seq_en = 1'b1;
      wait_ph(LCC_PH1);
      cmp({7'h0, seq_phase_end}, 8'h00);
      for (int i = 1; i < 6; i++) begin
         tick;
         cmp({5'h0, seq_phase}, {5'h0, ord_t[i % 5]});
         cmp({7'h0, seq_phase_end}, 8'h01);
      end
      seq_en = 1'b0;
      wait_ph(LCC_IDLE);
   endtask
   // Phase lengths 1..5 steps
   task t_seq_len;
      int n;
      for (int i = 1; i < 6; i++) wr(addr_t[i], 8'(i));
      seq_en = 1'b1;
      for (int i = 0; i < 5; i++) begin
         wait_ph(ord_t[i]);
         n = 0;
         while (seq_phase === ord_t[i] && n < 200) begin tick; n++; end
         if (seq_phase === ord_t[i]) begin
            cmp_rng(n, 0, 199);
            summarize;
         end
         cmp_rng(n, (i + 1) * ST * OD, (i + 1) * ST * OD + 1);
         cmp({7'h0, seq_phase_end}, 8'h01);
      end
      seq_en = 1'b0;
      wait_ph(LCC_IDLE);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      t_reset;
      t_fields;
      t_ramp;
      t_seq_zero;
      t_seq_len;
      t_rst_mid;
      summarize;
   end
endmodule
